/* File: hdl/pcs_pkg.sv */
// Operation
// - Bit 6 reads back the PLL lock pin, 1 while locked.
// - Power control bit 7 at 0 powers down; at 1 normal operation.
// - Setting power control to 1 never reloads nonvolatile configuration.
// - Bit 8 written 1, 0, 1 resynchronises all output dividers.
// - Bit 13 picks calibration trigger: 0 power toggle, 1 bit 20.
// - With select at 1, bit 20 written 1, 0, 1 calibrates VCO.
// - With select at 0, bit 20 is stored and read back but starts no calibration.
package pcs_pkg;
   localparam logic [3:0] pcs_reg_addr = 4'h2;
   localparam int pcs_width = 28;
   localparam int pcs_lock_bit = 6;
   localparam int pcs_pwr_bit = 7;
   localparam int pcs_sync_bit = 8;
   localparam int pcs_ver_lsb = 10;
   localparam int pcs_sel_bit = 13;
   localparam int pcs_cal_bit = 20;
   localparam logic pcs_pwr_reset = 1'h1;
   localparam logic pcs_sel_reset = 1'h0;
   localparam logic pcs_sync_reset = 1'h1;
   localparam logic pcs_cal_reset = 1'h1;

   // Progress through a 1-0-1 sequence
   typedef enum logic [2:0] {
      pcs_seq_idle = 3'h1,
      pcs_seq_one = 3'h2,
      pcs_seq_zero = 3'h4
   } pcs_seq_t;

   typedef struct packed {
      logic [1:0] lock_sync;
      logic power_control_n;
      logic calibration_trigger_select;
      logic sync_bit;
      logic vco_calibration_trigger;
      pcs_seq_t sync_seq;
      pcs_seq_t cal_seq;
      logic power_down_n;
      logic resync_pulse;
      logic cal_pulse;
      logic [pcs_width-1:0] rdata;
   } pcs_state_t;
endpackage

/* File: hdl/pcs_ctrl.sv */
module pcs_ctrl #(
   parameter logic [2:0] revision = 3'h1 // Arbitrary value
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Register access
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [3:0] addr,
   input wire logic [pcs_pkg::pcs_width-1:0] wdata,
   output logic [pcs_pkg::pcs_width-1:0] rdata,
   // PLL side
   input wire logic pll_lock_status,
   output logic power_down_n,
   output logic resync_pulse,
   output logic cal_pulse
);
   pcs_pkg::pcs_state_t s, next_s;
   logic hit;
   logic [pcs_pkg::pcs_width-1:0] image;

   // Field map must fit; an overlap would corrupt readback
   if (pcs_pkg::pcs_cal_bit >= pcs_pkg::pcs_width) begin : g_fit_chk
      $error("register fields do not fit the word");
   end
   if (pcs_pkg::pcs_lock_bit >= pcs_pkg::pcs_pwr_bit ||
       pcs_pkg::pcs_pwr_bit >= pcs_pkg::pcs_sync_bit ||
       pcs_pkg::pcs_sync_bit >= pcs_pkg::pcs_ver_lsb) begin : g_low_chk
      $error("low register fields overlap");
   end
   if (pcs_pkg::pcs_ver_lsb + 2 >= pcs_pkg::pcs_sel_bit ||
       pcs_pkg::pcs_sel_bit >= pcs_pkg::pcs_cal_bit) begin : g_high_chk
      $error("high register fields overlap");
   end

   always_comb begin
      next_s = s;
      hit = wr_en && (addr == pcs_pkg::pcs_reg_addr);
      next_s.lock_sync = {s.lock_sync[0], pll_lock_status};
      next_s.resync_pulse = 1'h0;
      next_s.cal_pulse = 1'h0;
      if (hit) begin
         next_s.power_control_n = wdata[pcs_pkg::pcs_pwr_bit];
         next_s.calibration_trigger_select = wdata[pcs_pkg::pcs_sel_bit];
         next_s.sync_bit = wdata[pcs_pkg::pcs_sync_bit];
         next_s.vco_calibration_trigger = wdata[pcs_pkg::pcs_cal_bit];
         // Sync sequence: 1 then 0 then 1
         case (s.sync_seq)
            pcs_pkg::pcs_seq_zero: begin
               if (wdata[pcs_pkg::pcs_sync_bit]) begin
                  next_s.resync_pulse = 1'h1;
                  next_s.sync_seq = pcs_pkg::pcs_seq_one;
               end
            end
            default: begin
               next_s.sync_seq = wdata[pcs_pkg::pcs_sync_bit] ?
                  pcs_pkg::pcs_seq_one : pcs_pkg::pcs_seq_idle;
               if (s.sync_seq == pcs_pkg::pcs_seq_one &&
                   !wdata[pcs_pkg::pcs_sync_bit]) begin
                  next_s.sync_seq = pcs_pkg::pcs_seq_zero;
               end
            end
         endcase
         // Calibration sequence tracked only while select is 1
         if (!s.calibration_trigger_select) begin
            next_s.cal_seq = pcs_pkg::pcs_seq_idle;
         end else begin
            case (s.cal_seq)
               pcs_pkg::pcs_seq_zero: begin
                  if (wdata[pcs_pkg::pcs_cal_bit]) begin
                     next_s.cal_pulse = 1'h1;
                     next_s.cal_seq = pcs_pkg::pcs_seq_one;
                  end
               end
               default: begin
                  next_s.cal_seq = wdata[pcs_pkg::pcs_cal_bit] ?
                     pcs_pkg::pcs_seq_one : pcs_pkg::pcs_seq_idle;
                  if (s.cal_seq == pcs_pkg::pcs_seq_one &&
                      !wdata[pcs_pkg::pcs_cal_bit]) begin
                     next_s.cal_seq = pcs_pkg::pcs_seq_zero;
                  end
               end
            endcase
         end
         // Power toggle calibrates when select is 0; no reload on power-up
         if (!s.calibration_trigger_select && !s.power_control_n &&
             wdata[pcs_pkg::pcs_pwr_bit]) begin
            next_s.cal_pulse = 1'h1;
         end
      end
      next_s.power_down_n = next_s.power_control_n;
      image = '0;
      image[pcs_pkg::pcs_lock_bit] = s.lock_sync[1];
      image[pcs_pkg::pcs_pwr_bit] = s.power_control_n;
      image[pcs_pkg::pcs_sync_bit] = s.sync_bit;
      image[pcs_pkg::pcs_ver_lsb +: 3] = revision;
      image[pcs_pkg::pcs_sel_bit] = s.calibration_trigger_select;
      image[pcs_pkg::pcs_cal_bit] = s.vco_calibration_trigger;
      next_s.rdata = (rd_en && addr == pcs_pkg::pcs_reg_addr) ? image : '0;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s <= '0;
         s.power_control_n <= pcs_pkg::pcs_pwr_reset;
         s.power_down_n <= pcs_pkg::pcs_pwr_reset;
         s.calibration_trigger_select <= pcs_pkg::pcs_sel_reset;
         s.sync_bit <= pcs_pkg::pcs_sync_reset;
         s.vco_calibration_trigger <= pcs_pkg::pcs_cal_reset;
         s.sync_seq <= pcs_pkg::pcs_seq_one;
         s.cal_seq <= pcs_pkg::pcs_seq_idle;
      end else begin
         s <= next_s;
      end
   end

   assign rdata = s.rdata;
   assign power_down_n = s.power_down_n;
   assign resync_pulse = s.resync_pulse;
   assign cal_pulse = s.cal_pulse;

   // Power control
   power_follow_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      (wr_en && addr == pcs_pkg::pcs_reg_addr) |=>
      power_down_n == $past(wdata[pcs_pkg::pcs_pwr_bit]))
      else $error("power state not following bit 7");

   power_hold_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      !(wr_en && addr == pcs_pkg::pcs_reg_addr) |=>
      $stable(power_down_n))
      else $error("power state moved without a write");

   // Power-up keeps what was written, nothing reloaded
   reload_none_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      (hit && !s.power_control_n && wdata[pcs_pkg::pcs_pwr_bit]) |=>
      s.sync_bit == $past(wdata[pcs_pkg::pcs_sync_bit]) &&
      s.vco_calibration_trigger == $past(wdata[pcs_pkg::pcs_cal_bit]) &&
      s.calibration_trigger_select == $past(wdata[pcs_pkg::pcs_sel_bit]))
      else $error("configuration changed on power-up");

   // Readback
   lock_read_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      (rd_en && addr == pcs_pkg::pcs_reg_addr) |=>
      rdata[pcs_pkg::pcs_lock_bit] == $past(s.lock_sync[1]))
      else $error("lock bit wrong on read");

   version_read_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      (rd_en && addr == pcs_pkg::pcs_reg_addr) |=>
      rdata[pcs_pkg::pcs_ver_lsb +: 3] == revision)
      else $error("version field altered");

   sel_read_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      (rd_en && addr == pcs_pkg::pcs_reg_addr) |=>
      rdata[pcs_pkg::pcs_sel_bit] == $past(s.calibration_trigger_select))
      else $error("select bit wrong on read");

   // Divider resync
   sync_seq_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      resync_pulse |-> $past(s.sync_seq) == pcs_pkg::pcs_seq_zero)
      else $error("resync without 1-0-1");

   sync_fire_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      (hit && s.sync_seq == pcs_pkg::pcs_seq_zero &&
       wdata[pcs_pkg::pcs_sync_bit]) |=> resync_pulse)
      else $error("1-0-1 on bit 8 gave no resync");

   sync_write_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      resync_pulse |-> $past(hit && wdata[pcs_pkg::pcs_sync_bit]))
      else $error("resync without a write of bit 8");

   sync_single_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      resync_pulse |=> !resync_pulse)
      else $error("resync pulse longer than one cycle");

   // Calibration
   cal_ignored_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      (s.calibration_trigger_select == 1'h0 &&
       !(wr_en && addr == pcs_pkg::pcs_reg_addr &&
         !s.power_control_n && wdata[pcs_pkg::pcs_pwr_bit])) |=>
      !cal_pulse)
      else $error("calibration without power toggle");

   power_cal_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      (hit && !s.calibration_trigger_select && !s.power_control_n &&
       wdata[pcs_pkg::pcs_pwr_bit]) |=> cal_pulse)
      else $error("power toggle did not calibrate");

   sel_power_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      (hit && s.calibration_trigger_select &&
       !(s.cal_seq == pcs_pkg::pcs_seq_zero &&
         wdata[pcs_pkg::pcs_cal_bit])) |=> !cal_pulse)
      else $error("calibration outside the bit 20 sequence");

   cal_seq_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      (cal_pulse && $past(s.calibration_trigger_select)) |->
      $past(s.cal_seq) == pcs_pkg::pcs_seq_zero)
      else $error("calibration without 1-0-1");

   cal_fire_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      (hit && s.calibration_trigger_select &&
       s.cal_seq == pcs_pkg::pcs_seq_zero &&
       wdata[pcs_pkg::pcs_cal_bit]) |=> cal_pulse)
      else $error("1-0-1 on bit 20 gave no calibration");

   cal_idle_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      (hit && !s.calibration_trigger_select) |=>
      s.cal_seq == pcs_pkg::pcs_seq_idle)
      else $error("bit 20 tracked while select is 0");

   cal_write_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      cal_pulse |-> $past(hit))
      else $error("calibration without a write");
endmodule // pcs_ctrl

/* File: bench/testbench.sv */
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'h0;
   logic rst = 1'h1;
   logic wr_en = 1'h0;
   logic rd_en = 1'h0;
   logic [3:0] addr = 4'h0;
   logic [pcs_pkg::pcs_width-1:0] wdata = '0;
   logic [pcs_pkg::pcs_width-1:0] rdata;
   logic pll_lock_status = 1'h0;
   logic power_down_n;
   logic resync_pulse;
   logic cal_pulse;
   int fails = 0;
   int checked = 0;
   int cal_cnt = 0;
   int rs_cnt = 0;
   always #12.5 ref_clk = ~ref_clk;
   // Pulses counted, so their exact cycle is left to the design
   always @(posedge ref_clk) begin
      if (cal_pulse === 1'h1) cal_cnt++;
      if (resync_pulse === 1'h1) rs_cnt++;
   end
   pcs_ctrl u_pcs_ctrl (.ref_clk(ref_clk), .rst(rst), .wr_en(wr_en),
      .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata),
      .pll_lock_status(pll_lock_status), .power_down_n(power_down_n),
      .resync_pulse(resync_pulse), .cal_pulse(cal_pulse));
   task automatic chk(string name, logic [27:0] seen, logic [27:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [27:0] d);
      @(posedge ref_clk);
      wr_en <= 1'h1;
      addr <= a;
      wdata <= d;
   endtask
   // Drop the strobe, then let outputs of the last write settle
   task automatic idle();
      @(posedge ref_clk);
      wr_en <= 1'h0;
      repeat (3) @(posedge ref_clk);
      #1;
   endtask
   task automatic rd(logic [3:0] a, logic [27:0] exp);
      @(posedge ref_clk);
      rd_en <= 1'h1;
      addr <= a;
      @(posedge ref_clk);
      rd_en <= 1'h0;
      #1;
      chk("rdata", rdata, exp);
   endtask
   task automatic finish_test();
      if (fails == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge ref_clk);
      rst <= 1'h0;
      rd(4'h2, 28'h100580);
      rd(4'h3, 28'h0);
      wr(4'h3, 28'h0);
      idle();
      rd(4'h2, 28'h100580);
      pll_lock_status <= 1'h1;
      repeat (4) @(posedge ref_clk);
      rd(4'h2, 28'h1005c0);
      wr(4'h2, 28'h101dbf);
      idle();
      rd(4'h2, 28'h1005c0);
      wr(4'h2, 28'h000100);
      idle();
      chk("power_down_n", 28'(power_down_n), 28'h0);
      wr(4'h2, 28'h000180);
      idle();
      chk("power_down_n", 28'(power_down_n), 28'h1);
      chk("cal_cnt", 28'(cal_cnt), 28'h1);
      // Bit 20 left at 0 shows no default came back on power-up
      rd(4'h2, 28'h0005c0);
      wr(4'h2, 28'h100180);
      wr(4'h2, 28'h000180);
      wr(4'h2, 28'h100180);
      idle();
      chk("cal_cnt", 28'(cal_cnt), 28'h1);
      chk("rs_cnt", 28'(rs_cnt), 28'h0);
      wr(4'h2, 28'h100080);
      wr(4'h2, 28'h100180);
      idle();
      chk("rs_cnt", 28'(rs_cnt), 28'h1);
      // Select must be stored before the 1-0-1 on bit 20 counts
      wr(4'h2, 28'h102180);
      wr(4'h2, 28'h102180);
      wr(4'h2, 28'h002180);
      wr(4'h2, 28'h102180);
      idle();
      chk("cal_cnt", 28'(cal_cnt), 28'h2);
      chk("power_down_n", 28'(power_down_n), 28'h1);
      rd(4'h2, 28'h1025c0);
      // Power toggle with select at 1 must not calibrate
      wr(4'h2, 28'h102100);
      wr(4'h2, 28'h102180);
      idle();
      chk("cal_cnt", 28'(cal_cnt), 28'h2);
      // Mid-run reset brings the defaults back
      @(posedge ref_clk);
      rst <= 1'h1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'h0;
      repeat (3) @(posedge ref_clk);
      rd(4'h2, 28'h1005c0);
      chk("power_down_n", 28'(power_down_n), 28'h1);
      finish_test();
   end
endmodule // testbench
